/* pkg/kwm_pkg.sv */
package kwm_pkg;
   // Register offsets on the runtime register port.
   localparam logic [7:0] OFS_MAKE1 = 8'h5f;
   localparam logic [7:0] OFS_MAKE2 = 8'h60;
   localparam logic [7:0] OFS_CTRL = 8'h64;
   // Control register field positions.
   localparam int CTRL_WAKE_BIT = 0;
   localparam int CTRL_DIS_BIT = 1;
   localparam int CTRL_SEL2_BIT = 2;
   localparam int CTRL_SEL3_BIT = 3;
   // Reset values.
   localparam logic [7:0] MAKE_RST = 8'h00;
   localparam logic [1:0] SEL_RST = 2'h0;
   localparam logic DIS_RST = 1'b0;
   // Wildcard value of a match byte.
   localparam logic [7:0] MAKE_ANY = 8'h00;
   // Frame positions, counted in falling link clock edges.
   localparam logic [3:0] CNT_PAR = 4'ha;
   localparam logic [3:0] CNT_END = 4'hb;
   // Timing.
   localparam int REF_CLK_HZ = 40_000_000;
   localparam int TMO_NS = 125_000;
   localparam int TMO_CYC = (TMO_NS / 1000) * (REF_CLK_HZ / 1_000_000);
   localparam int WAKE_MAX_NS = 100_000;
   localparam int WAKE_MAX_CYC = (WAKE_MAX_NS / 1000) * (REF_CLK_HZ / 1_000_000);
   typedef enum logic {
      KWM_FIRST = 1'b0,
      KWM_SECOND = 1'b1
   } kwm_state_e;
endpackage : kwm_pkg

/* src/kwm_matcher.sv */
`timescale 1ns/100ps
// Contract
// - Control bit 2 picks one-byte (0) or two-byte (1) make detection; bit 3 ignored.
// - One-byte mode: valid byte equal to first make byte raises wake event.
// - A make byte register of zero matches any valid byte.
// - Two-byte mode: first byte matches, then next byte must match second register.
// - Mismatch, parity error or timeout returns decode to first-byte search.
// - Two-byte mode: a byte after a matching first byte compares with second register; any other byte with first.
// - Link clock stuck 125 us mid-byte resets decode; next byte counts as first.
// - A detected make code raises the wake event, routed to wake output when asleep.
// - Data sampled on falling link clock; byte valid only with odd parity.
// - Disable bit 1 stops the matching logic; reset value 0 keeps it active.
// - With stop bit 1, wake event rises within 100 us of tenth falling edge.
module kwm_matcher #(
   parameter int TMO_CYCLES = kwm_pkg::TMO_CYC
) (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic kbd_clk_in,
   input wire logic kbd_data_in,
   input wire logic sleep_state_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   output logic [7:0] reg_rdata_out,
   output logic key_wake_event_out,
   output logic power_event_out_n_out
);
   // Link domain: the shift register is only read after ten edges, when it is quiet.
   logic [9:0] link_sh_r;
   logic [9:0] link_sh_nxt;

   always_comb begin
      link_sh_nxt = {kbd_data_in, link_sh_r[9:1]};
   end

   always_ff @(negedge kbd_clk_in) begin
      link_sh_r <= link_sh_nxt;
   end

   // Reference domain.
   logic keyboard_clock_line_s1_r, keyboard_clock_line_s2_r, keyboard_clock_line_s3_r, kdat_s1_r, kdat_s2_r;
   logic [7:0] mk1_r, mk1_nxt, mk2_r, mk2_nxt;
   logic [1:0] sel_r, sel_nxt;
   logic dis_r, dis_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [15:0] tmo_r, tmo_nxt;
   logic [9:0] word_r, word_nxt;
   kwm_pkg::kwm_state_e st_r, st_nxt;
   logic evt_r, evt_nxt, wake_r, wake_nxt;
   logic [7:0] rdata_nxt;
   logic fall, rise, timeout, eval, valid, bad, match1, match2;
   logic [7:0] rx_byte;

   always_ff @(posedge ref_clk_in) begin
      keyboard_clock_line_s1_r <= kbd_clk_in;
      keyboard_clock_line_s2_r <= keyboard_clock_line_s1_r;
      keyboard_clock_line_s3_r <= keyboard_clock_line_s2_r;
      kdat_s1_r <= kbd_data_in;
      kdat_s2_r <= kdat_s1_r;
   end

   assign fall = keyboard_clock_line_s3_r & ~keyboard_clock_line_s2_r;
   assign rise = ~keyboard_clock_line_s3_r & keyboard_clock_line_s2_r;
   assign rx_byte = word_r[8:1];
   assign timeout = (cnt_r != 4'h0) && (tmo_r == 16'(TMO_CYCLES - 1)) && !fall && !rise;
   // The stop bit is read as the clock rises after the tenth fall; a keyboard that changes
   // data later in the high phase would have its parity bit judged as the stop bit.
   // decide at stop bit
   assign eval = rise && (cnt_r == kwm_pkg::CNT_PAR);
   assign valid = eval && !word_r[0] && (^word_r[9:1]) && kdat_s2_r;
   assign bad = (eval && !valid) || timeout;
   assign match1 = (mk1_r == kwm_pkg::MAKE_ANY) || (rx_byte == mk1_r);
   assign match2 = (mk2_r == kwm_pkg::MAKE_ANY) || (rx_byte == mk2_r);

   // Register port.
   always_comb begin
      mk1_nxt = mk1_r;
      mk2_nxt = mk2_r;
      sel_nxt = sel_r;
      dis_nxt = dis_r;
      if (reg_wr_in) begin
         if (reg_addr_in == kwm_pkg::OFS_MAKE1) begin
            mk1_nxt = reg_wdata_in;
         end
         if (reg_addr_in == kwm_pkg::OFS_MAKE2) begin
            mk2_nxt = reg_wdata_in;
         end
         if (reg_addr_in == kwm_pkg::OFS_CTRL) begin
            sel_nxt = reg_wdata_in[kwm_pkg::CTRL_SEL3_BIT:kwm_pkg::CTRL_SEL2_BIT];
            dis_nxt = reg_wdata_in[kwm_pkg::CTRL_DIS_BIT];
         end
      end
      rdata_nxt = 8'h00;
      case (reg_addr_in)
         kwm_pkg::OFS_MAKE1: rdata_nxt = mk1_r;
         kwm_pkg::OFS_MAKE2: rdata_nxt = mk2_r;
         kwm_pkg::OFS_CTRL: begin
            rdata_nxt[kwm_pkg::CTRL_SEL3_BIT:kwm_pkg::CTRL_SEL2_BIT] = sel_r;
            rdata_nxt[kwm_pkg::CTRL_DIS_BIT] = dis_r;
            rdata_nxt[kwm_pkg::CTRL_WAKE_BIT] = wake_r;
         end
         default: rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         mk1_r <= kwm_pkg::MAKE_RST;
         mk2_r <= kwm_pkg::MAKE_RST;
         sel_r <= kwm_pkg::SEL_RST;
         dis_r <= kwm_pkg::DIS_RST;
         reg_rdata_out <= 8'h00;
      end else begin
         mk1_r <= mk1_nxt;
         mk2_r <= mk2_nxt;
         sel_r <= sel_nxt;
         dis_r <= dis_nxt;
         reg_rdata_out <= rdata_nxt;
      end
   end

   // Framing, timeout and make decode.
   always_comb begin
      cnt_nxt = cnt_r;
      tmo_nxt = tmo_r;
      word_nxt = word_r;
      st_nxt = st_r;
      evt_nxt = 1'b0;
      if (fall || rise || cnt_r == 4'h0) begin
         tmo_nxt = 16'h0000;
      end else begin
         tmo_nxt = tmo_r + 16'h0001;
      end
      if (fall) begin
         cnt_nxt = (cnt_r >= kwm_pkg::CNT_END - 4'h1) ? 4'h0 : cnt_r + 4'h1;
         if (cnt_r == kwm_pkg::CNT_PAR - 4'h1) begin
            word_nxt = link_sh_r;
         end
      end
      if (timeout) begin
         cnt_nxt = 4'h0;
         tmo_nxt = 16'h0000;
      end
      if (bad) begin
         st_nxt = kwm_pkg::KWM_FIRST;
      end else if (valid) begin
         if (!sel_r[0]) begin
            evt_nxt = match1;
            st_nxt = kwm_pkg::KWM_FIRST;
         end else begin
            case (st_r)
               kwm_pkg::KWM_FIRST: begin
                  st_nxt = match1 ? kwm_pkg::KWM_SECOND : kwm_pkg::KWM_FIRST;
               end
               kwm_pkg::KWM_SECOND: begin
                  evt_nxt = match2;
                  st_nxt = kwm_pkg::KWM_FIRST;
               end
               default: st_nxt = kwm_pkg::KWM_FIRST;
            endcase
         end
      end
      wake_nxt = sleep_state_in && (wake_r || evt_r);
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in || dis_r) begin
         cnt_r <= 4'h0;
         tmo_r <= 16'h0000;
         word_r <= 10'h000;
         st_r <= kwm_pkg::KWM_FIRST;
         evt_r <= 1'b0;
         wake_r <= 1'b0;
         key_wake_event_out <= 1'b0;
         power_event_out_n_out <= 1'b1;
      end else begin
         cnt_r <= cnt_nxt;
         tmo_r <= tmo_nxt;
         word_r <= word_nxt;
         st_r <= st_nxt;
         evt_r <= evt_nxt;
         wake_r <= wake_nxt;
         key_wake_event_out <= evt_nxt;
         power_event_out_n_out <= ~wake_nxt;
      end
   end

   // Checks.
   property p_single;
      @(posedge ref_clk_in) disable iff (srst_in)
      valid && !dis_r && !sel_r[0] && rx_byte == mk1_r |=> key_wake_event_out;
   endproperty
   a_single: assert property (p_single) else $error("single byte match missed");

   property p_wild;
      @(posedge ref_clk_in) disable iff (srst_in)
      valid && !dis_r && !sel_r[0] && mk1_r == 8'h00 |=> key_wake_event_out;
   endproperty
   a_wild: assert property (p_wild) else $error("wildcard did not match");

   property p_mode;
      @(posedge ref_clk_in) disable iff (srst_in)
      sel_r[0] && st_r == kwm_pkg::KWM_FIRST |=> !key_wake_event_out;
   endproperty
   a_mode: assert property (p_mode) else $error("event without second byte");

   property p_first;
      @(posedge ref_clk_in) disable iff (srst_in)
      valid && !dis_r && sel_r[0] && st_r == kwm_pkg::KWM_FIRST && match1
      |=> st_r == kwm_pkg::KWM_SECOND && !key_wake_event_out;
   endproperty
   a_first: assert property (p_first) else $error("first byte not accepted");

   property p_second;
      @(posedge ref_clk_in) disable iff (srst_in)
      valid && !dis_r && sel_r[0] && st_r == kwm_pkg::KWM_SECOND
      |=> key_wake_event_out == $past(match2) && st_r == kwm_pkg::KWM_FIRST;
   endproperty
   a_second: assert property (p_second) else $error("second byte decision wrong");

   property p_bad;
      @(posedge ref_clk_in) disable iff (srst_in)
      bad |=> st_r == kwm_pkg::KWM_FIRST && !key_wake_event_out;
   endproperty
   a_bad: assert property (p_bad) else $error("decode not restarted");

   property p_tmo;
      @(posedge ref_clk_in) disable iff (srst_in)
      timeout |=> cnt_r == 4'h0;
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout left framing");

   property p_par;
      @(posedge ref_clk_in) disable iff (srst_in)
      key_wake_event_out |-> $past(^word_r[9:1]) && !$past(word_r[0]);
   endproperty
   a_par: assert property (p_par) else $error("event from bad frame");

   property p_dis;
      @(posedge ref_clk_in) disable iff (srst_in)
      dis_r |=> !key_wake_event_out && power_event_out_n_out;
   endproperty
   a_dis: assert property (p_dis) else $error("active while disabled");

   property p_pme;
      @(posedge ref_clk_in) disable iff (srst_in)
      key_wake_event_out && sleep_state_in && !dis_r |=> !power_event_out_n_out;
   endproperty
   a_pme: assert property (p_pme) else $error("wake output not asserted");

   // Cycles since the tenth fall of the current frame, saturating, for the deadline check.
   logic [15:0] since_r;
   logic [15:0] since_nxt;

   always_comb begin
      since_nxt = since_r;
      if (fall && cnt_r == kwm_pkg::CNT_PAR - 4'h1) begin
         since_nxt = 16'h0000;
      end else if (since_r != 16'hffff) begin
         since_nxt = since_r + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         since_r <= 16'hffff;
      end else begin
         since_r <= since_nxt;
      end
   end

   property p_late;
      @(posedge ref_clk_in) disable iff (srst_in)
      key_wake_event_out |-> since_r < 16'(kwm_pkg::WAKE_MAX_CYC);
   endproperty
   a_late: assert property (p_late) else $error("decision too late");

   property p_pulse;
      @(posedge ref_clk_in) disable iff (srst_in)
      key_wake_event_out |=> !key_wake_event_out;
   endproperty
   a_pulse: assert property (p_pulse) else $error("wake event wider than one cycle");

   property p_cause;
      @(posedge ref_clk_in) disable iff (srst_in)
      key_wake_event_out |-> $past(valid) && !$past(dis_r);
   endproperty
   a_cause: assert property (p_cause) else $error("wake event without a valid byte");

   property p_awake;
      @(posedge ref_clk_in) disable iff (srst_in)
      !sleep_state_in |=> power_event_out_n_out;
   endproperty
   a_awake: assert property (p_awake) else $error("wake output low while awake");

   c_single: cover property (@(posedge ref_clk_in) !sel_r[0] && key_wake_event_out);
   c_bad: cover property (@(posedge ref_clk_in) bad && !timeout);
   c_double: cover property (@(posedge ref_clk_in) sel_r[0] && key_wake_event_out);
   c_tmo: cover property (@(posedge ref_clk_in) timeout);
   c_pme: cover property (@(posedge ref_clk_in) !power_event_out_n_out);
endmodule : kwm_matcher

/* tb/kwm_kbd_model.sv */
`timescale 1ns/100ps
module kwm_kbd_model (
   output logic kbd_clk_out,
   output logic kbd_data_out
);
   initial begin
      kbd_clk_out = 1'b1;
      kbd_data_out = 1'b1;
   end
   task automatic send(input logic [7:0] b, input bit bad_par, input bit stall);
      logic [10:0] f;
      f = {1'b1, (~^b) ^ bad_par, b, 1'b0};
      kbd_data_out = f[0];
      for (int i = 0; i < 11; i++) begin
         #31.25;
         kbd_clk_out = 1'b0;
         if (stall && i == 5) begin
            #8000;
            break;
         end
         #62.5;
         kbd_clk_out = 1'b1;
         // The next bit goes out with the rising edge, so the stop bit stands at the tenth rise.
         kbd_data_out = (i < 10) ? f[i + 1] : 1'b1;
         #31.25;
      end
      // Released lines rest at the pull-up level, so the clock stands still between frames.
      kbd_clk_out = 1'b1;
      kbd_data_out = 1'b1;
      #1500;
   endtask : send
endmodule : kwm_kbd_model

/* tb/tb_kwm_matcher.sv */
`timescale 1ns/100ps
module tb_kwm_matcher;
   logic ref_clk_in, srst_in, keyboard_clock_line, kdat, sleep, wr, evt, pe_n;
   logic [7:0] addr, wdata, rdata, m1, m2, r;
   int err_count, comparisons, pulses, st;
   bit two, dis;
   // A short timeout (200 cycles, 5 us) fires inside the model's 8000 ns stall.
   kwm_matcher #(.TMO_CYCLES(200)) dut_u (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
      .kbd_clk_in(keyboard_clock_line), .kbd_data_in(kdat), .sleep_state_in(sleep), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rdata_out(rdata),
      .key_wake_event_out(evt), .power_event_out_n_out(pe_n));
   kwm_kbd_model kbd_u (.kbd_clk_out(keyboard_clock_line), .kbd_data_out(kdat));
   initial begin
      ref_clk_in = 1'b0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in) if (evt === 1'b1) pulses++;
   task chk_byte(string n, logic [7:0] e, logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk_byte
   task chk_bit(string n, logic e, logic g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %b seen %b", n, e, g);
      end
   endtask : chk_bit
   task wr_reg(logic [7:0] a, logic [7:0] d);
      @(negedge ref_clk_in);
      addr = a;
      wdata = d;
      wr = 1'b1;
      if (a == kwm_pkg::OFS_MAKE1) m1 = d;
      if (a == kwm_pkg::OFS_MAKE2) m2 = d;
      if (a == kwm_pkg::OFS_CTRL) begin
         two = d[kwm_pkg::CTRL_SEL2_BIT];
         dis = d[kwm_pkg::CTRL_DIS_BIT];
      end
      @(negedge ref_clk_in);
      wr = 1'b0;
   endtask : wr_reg
   task rd_chk(logic [7:0] a, logic [7:0] e);
      @(negedge ref_clk_in);
      addr = a;
      @(negedge ref_clk_in);
      chk_byte("reg_rdata_out", e, rdata);
   endtask : rd_chk
   // The reference model keeps the two-byte search state in st.
   task key(logic [7:0] b, bit bp = 0, bit stl = 0);
      int e;
      e = 0;
      if (dis || bp || stl) st = 0;
      else if (!two) e = (m1 == 8'h00 || b == m1);
      else if (st == 0) st = (m1 == 8'h00 || b == m1);
      else begin
         e = (m2 == 8'h00 || b == m2);
         st = 0;
      end
      pulses = 0;
      kbd_u.send(b, bp, stl);
      chk_byte("wake_pulses", 8'(e), 8'(pulses));
   endtask : key
   task conclude;
      $display("Comparisons %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude
   initial begin
      #2000000;
      err_count++;
      conclude();
   end
   initial begin
      {srst_in, sleep, wr, addr, wdata, m1, m2} = {1'b1, 2'b00, 8'h00, 8'h00, 8'h00, 8'h00};
      {err_count, comparisons, st, two, dis} = 0;
      void'($urandom(70));
      repeat (3) @(negedge ref_clk_in);
      srst_in = 1'b0;
      rd_chk(kwm_pkg::OFS_MAKE1, 8'h00);
      rd_chk(kwm_pkg::OFS_MAKE2, 8'h00);
      rd_chk(kwm_pkg::OFS_CTRL, 8'h00);
      rd_chk(8'h61, 8'h00);
      chk_bit("power_event_out_n_out", 1'b1, pe_n);
      key(8'($urandom));
      r = 8'($urandom) | 8'h01;
      wr_reg(kwm_pkg::OFS_MAKE1, r);
      rd_chk(kwm_pkg::OFS_MAKE1, r);
      wr_reg(kwm_pkg::OFS_CTRL, 8'h08);
      rd_chk(kwm_pkg::OFS_CTRL, 8'h08);
      key(r);
      key(r ^ 8'h01);
      key(r, 1);
      wr_reg(kwm_pkg::OFS_MAKE1, 8'he0);
      wr_reg(kwm_pkg::OFS_MAKE2, 8'h37);
      rd_chk(kwm_pkg::OFS_MAKE2, 8'h37);
      wr_reg(kwm_pkg::OFS_CTRL, 8'h04);
      key(8'he0);
      key(8'h37);
      key(8'h37);
      key(8'he0);
      key(8'he0);
      key(8'h37);
      key(8'he0);
      key(8'h37, 1);
      key(8'h37);
      key(8'he0);
      key(8'h37, 0, 1);
      key(8'h37);
      wr_reg(kwm_pkg::OFS_MAKE2, 8'h00);
      key(8'he0);
      key(8'($urandom));
      @(negedge ref_clk_in);
      sleep = 1'b1;
      key(8'he0);
      key(8'he0);
      chk_bit("power_event_out_n_out", 1'b0, pe_n);
      rd_chk(kwm_pkg::OFS_CTRL, 8'h05);
      @(negedge ref_clk_in);
      sleep = 1'b0;
      repeat (2) @(negedge ref_clk_in);
      chk_bit("power_event_out_n_out", 1'b1, pe_n);
      rd_chk(kwm_pkg::OFS_CTRL, 8'h04);
      wr_reg(kwm_pkg::OFS_CTRL, 8'h06);
      key(8'he0);
      key(8'he0);
      wr_reg(kwm_pkg::OFS_CTRL, 8'h04);
      key(8'he0);
      key(8'he0);
      conclude();
   end
endmodule : tb_kwm_matcher
